// ==== src/ddc_pkg.sv ====
// constants and types for the dma descriptor error checker
package ddc_pkg;
  localparam int AW         = 32;
  localparam int ENGINES    = 4;
  // status word layout
  localparam int ST_BUSY    = 26;
  localparam int ST_ERR_BUF = 27;
  localparam int ST_ERR_CMP = 28;
  localparam int ST_ERR_NXT = 29;
  localparam int ST_ERR_CUR = 30;
  localparam int ST_ERR_BSY = 31;
  localparam int ST_STOPPED = 25;
  // descriptor flag positions in the fetched status word
  localparam int DF_CMP     = 0;
  localparam int DF_SOE     = 1;
  localparam int DF_IOE     = 2;
  localparam int DF_LAST    = 3;
  localparam int DF_FIRST   = 4;
  localparam int DF_W       = 5;
  localparam logic [AW-1:0] MEM_LO_DEF = 32'h0000_0000;
  localparam logic [AW-1:0] MEM_HI_DEF = 32'h0fff_ffff;
  localparam logic [3:0]    CMP_CHK_DEF = 4'hf;
  typedef enum logic [2:0] {EN_IDLE, EN_FETCH, EN_CHECK, EN_MOVE, EN_WBACK} ddc_state_type;
endpackage

// ==== src/ddc_engine.sv ====
// one descriptor engine with error checking
`timescale 1ns/10ps
module ddc_engine
#(
  parameter logic [ddc_pkg::AW-1:0] MEM_LO       = ddc_pkg::MEM_LO_DEF,
  parameter logic [ddc_pkg::AW-1:0] MEM_HI       = ddc_pkg::MEM_HI_DEF,
  // per-engine build option for the completed-descriptor check
  parameter bit                     DONE_RECHECK = 1'b1
)(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  // software pointer port
  input  wire logic                       curPtrWrite,
  input  wire logic [ddc_pkg::AW-1:0]     curPtrData,
  output logic      [ddc_pkg::AW-1:0]     curPtr,
  output logic      [31:0]                status,
  output logic                            irqPulse,
  // descriptor fetch: request address, answer with fields
  output logic                            descReq,
  output logic      [ddc_pkg::AW-1:0]     descAddr,
  input  wire logic                       descValid,
  input  wire logic [ddc_pkg::AW-1:0]     descBufAddr,
  input  wire logic [ddc_pkg::AW-1:0]     descBufLen,
  input  wire logic [ddc_pkg::AW-1:0]     descNext,
  input  wire logic [ddc_pkg::DF_W-1:0]   descFlags,
  // completion write-back of the done flag
  output logic                            doneWrite,
  output logic      [ddc_pkg::DF_W-1:0]   doneFlags,
  // data movement over the streaming side
  output logic                            moveReq,
  output logic                            packetFirstFlag,
  output logic                            packetLastFlag,
  input  wire logic                       moveDone
);
  import ddc_pkg::*;

  ddc_state_type state;
  logic [AW-1:0]   nextPtr;
  logic [DF_W-1:0] flags;
  // error flags in status order: buffer, completed, next, current, busy write
  logic [4:0]      errBits;
  logic [AW:0]     bufEnd;

  // one window test shared by the pointer, buffer and next-pointer checks
  function automatic logic addrOk(input logic [AW-1:0] a);
    addrOk = (a >= MEM_LO) && (a <= MEM_HI);
  endfunction

  wire busy = (state != EN_IDLE);
  // one bit wider so a buffer running off the top of memory cannot wrap and pass
  assign bufEnd = {1'b0, descBufAddr} + {1'b0, descBufLen};

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state   <= EN_IDLE;
      curPtr  <= '0;
      nextPtr <= '0;
      flags   <= '0;
      errBits <= '0;
    end
    else if (curPtrWrite && busy)
    begin
      // the old pointer is kept so software still sees where the chain stood
      state      <= EN_IDLE;
      errBits[ST_ERR_BSY-ST_ERR_BUF] <= 1'b1;
    end
    else if (curPtrWrite)
    begin
      curPtr  <= curPtrData;
      errBits <= '0;
      if (addrOk(curPtrData))
        state <= EN_FETCH;
      else
        errBits[ST_ERR_CUR-ST_ERR_BUF] <= 1'b1;
    end
    else
    begin
      case (state)
        EN_FETCH:
          if (descValid)
          begin
            flags   <= descFlags;
            nextPtr <= descNext;
            // a stale descriptor is reported as such, whatever its other fields
            if (DONE_RECHECK && descFlags[DF_CMP])
            begin
              errBits[ST_ERR_CMP-ST_ERR_BUF] <= 1'b1;
              state      <= EN_IDLE;
            end
            else if (!addrOk(descBufAddr))
            begin
              errBits[ST_ERR_BUF-ST_ERR_BUF] <= 1'b1;
              state      <= EN_IDLE;
            end
            else if (bufEnd > {1'b0, MEM_HI} + 33'h1)
            begin
              errBits[ST_ERR_BUF-ST_ERR_BUF] <= 1'b1;
              state      <= EN_IDLE;
            end
            else
              state <= EN_MOVE;
          end
        EN_MOVE:
          if (moveDone)
            state <= EN_WBACK;
        EN_WBACK:
        begin
          // stop-on-end wins over a bad next pointer: the chain is meant to end here
          if (flags[DF_SOE])
            state <= EN_IDLE;
          else if (!addrOk(nextPtr))
          begin
            errBits[ST_ERR_NXT-ST_ERR_BUF] <= 1'b1;
            state      <= EN_IDLE;
          end
          else
          begin
            curPtr <= nextPtr;
            state  <= EN_FETCH;
          end
        end
        default:
          state <= EN_IDLE;
      endcase
    end
  end

  assign descReq   = (state == EN_FETCH);
  assign descAddr  = curPtr;
  assign moveReq   = (state == EN_MOVE);
  assign doneWrite = (state == EN_WBACK);
  assign doneFlags = flags | (DF_W'(1) << DF_CMP);
  assign packetFirstFlag = flags[DF_FIRST];
  assign packetLastFlag  = flags[DF_LAST];
  // only the write-back of a descriptor that asked for it may interrupt
  assign irqPulse  = doneWrite && flags[DF_IOE];

  always_comb
  begin
    status = '0;
    status[ST_BUSY]    = busy;
    status[ST_STOPPED] = !busy;
    status[ST_ERR_BSY:ST_ERR_BUF] = errBits;
  end

  a_busy_write_err: assert property (@(posedge clock) disable iff (!rstn)
    curPtrWrite && busy |=> !busy && status[ST_ERR_BSY])
    else $error("busy write did not stop engine");
  a_irq_only_ioe: assert property (@(posedge clock) disable iff (!rstn)
    irqPulse |-> flags[DF_IOE] && $past(moveReq && moveDone))
    else $error("interrupt without interrupt-on-end");
  a_cur_ptr_err: assert property (@(posedge clock) disable iff (!rstn)
    curPtrWrite && !busy && !addrOk(curPtrData) |=> !busy && status[ST_ERR_CUR])
    else $error("bad current pointer not flagged");
  a_done_flag_err: assert property (@(posedge clock) disable iff (!rstn)
    state == EN_FETCH && descValid && descFlags[DF_CMP] && DONE_RECHECK && !curPtrWrite
    |=> status[ST_ERR_CMP] && !busy)
    else $error("completed descriptor not flagged");
  a_buf_addr_err: assert property (@(posedge clock) disable iff (!rstn)
    state == EN_FETCH && descValid && !descFlags[DF_CMP] && !addrOk(descBufAddr)
    && !curPtrWrite |=> status[ST_ERR_BUF])
    else $error("bad buffer address not flagged");
  a_stop_on_end: assert property (@(posedge clock) disable iff (!rstn)
    state == EN_WBACK && flags[DF_SOE] && !curPtrWrite
    |=> !busy ##1 (!busy || $past(curPtrWrite)))
    else $error("stop-on-end did not halt");
  a_next_ptr_err: assert property (@(posedge clock) disable iff (!rstn)
    state == EN_WBACK && !flags[DF_SOE] && !addrOk(nextPtr) && !curPtrWrite
    |=> status[ST_ERR_NXT])
    else $error("bad next pointer not flagged");
  a_start_fetch: assert property (@(posedge clock) disable iff (!rstn)
    curPtrWrite && !busy && addrOk(curPtrData) |=> descReq && descAddr == $past(curPtrData))
    else $error("pointer write did not start fetch");

  // a finished move with no pointer write in the same cycle is followed by a write-back that marks the descriptor done
  sequence s_move_finish;
    moveReq && moveDone && !curPtrWrite;
  endsequence
  sequence s_mark_done;
    doneWrite && doneFlags[DF_CMP];
  endsequence
  // the hop from a finished descriptor to the next one of a valid chain
  sequence s_chain_hop;
    state == EN_WBACK && !flags[DF_SOE] && addrOk(nextPtr) && !curPtrWrite;
  endsequence
  sequence s_next_fetch;
    descReq && status[ST_BUSY] && descAddr == $past(nextPtr);
  endsequence
  a_done_mark: assert property (@(posedge clock) disable iff (!rstn)
    s_move_finish |=> s_mark_done)
    else $error("finished descriptor not marked done");
  a_chain_follow: assert property (@(posedge clock) disable iff (!rstn)
    s_chain_hop |=> s_next_fetch)
    else $error("engine did not follow the next pointer");
  a_buf_len_err: assert property (@(posedge clock) disable iff (!rstn)
    state == EN_FETCH && descValid && !(DONE_RECHECK && descFlags[DF_CMP])
    && addrOk(descBufAddr) && bufEnd > {1'b0, MEM_HI} + 33'h1 && !curPtrWrite
    |=> status[ST_ERR_BUF] && !busy)
    else $error("buffer overrun not flagged");
  a_move_busy: assert property (@(posedge clock) disable iff (!rstn)
    moveReq && !moveDone && !curPtrWrite |=> moveReq && status[ST_BUSY])
    else $error("engine left the move early or dropped busy");
  a_fetch_stands: assert property (@(posedge clock) disable iff (!rstn)
    descReq && !descValid && !curPtrWrite |=> descReq && descAddr == $past(descAddr))
    else $error("descriptor request dropped before its answer");
  a_error_hold: assert property (@(posedge clock) disable iff (!rstn)
    status[ST_ERR_BSY:ST_ERR_BUF] != '0 && !busy && !curPtrWrite
    |=> !busy && $stable(status[ST_ERR_BSY:ST_ERR_BUF]))
    else $error("error flags or halt not held");
  a_ptr_load: assert property (@(posedge clock) disable iff (!rstn)
    curPtrWrite && !busy |=> curPtr == $past(curPtrData))
    else $error("pointer write not loaded");
  a_busy_keep_ptr: assert property (@(posedge clock) disable iff (!rstn)
    curPtrWrite && busy |=> $stable(curPtr))
    else $error("busy write changed the pointer");
  a_recheck_off: assert property (@(posedge clock) disable iff (!rstn)
    state == EN_FETCH && descValid && !DONE_RECHECK && !curPtrWrite
    |=> !status[ST_ERR_CMP])
    else $error("completed error raised with the check disabled");
endmodule

// ==== dv/ddc_mem_model.sv ====
// descriptor memory and packet peer model facing one engine
`timescale 1ns/10ps
module ddc_mem_model
(
  // engine side
  input  wire logic                     clock,
  input  wire logic                     scrub,
  input  wire logic                     descReq,
  input  wire logic [ddc_pkg::AW-1:0]   descAddr,
  output logic                          descValid,
  output logic      [ddc_pkg::AW-1:0]   descBufAddr,
  output logic      [ddc_pkg::AW-1:0]   descBufLen,
  output logic      [ddc_pkg::AW-1:0]   descNext,
  output logic      [ddc_pkg::DF_W-1:0] descFlags,
  input  wire logic                     doneWrite,
  input  wire logic [ddc_pkg::DF_W-1:0] doneFlags,
  input  wire logic                     moveReq,
  output logic                          moveDone
);
  import ddc_pkg::*;
  logic [3*AW+DF_W-1:0] ring [4];
  logic [3:0]           cnt = 4'h0;
  logic                 slow = 1'b0;
  logic [1:0]           idx = 2'b00;
  // fields are only good in the answer cycle; otherwise show inverted junk
  assign {descBufAddr, descBufLen, descNext, descFlags} =
    descValid ? ring[descAddr[5:4]] : ~ring[descAddr[5:4]];
  always @(posedge clock)
  begin
    descValid <= 1'b0;
    moveDone  <= 1'b0;
    if (descReq)
      idx <= descAddr[5:4];
    // alternate a prompt and a slow answer
    if ((descReq || moveReq) && !descValid && !moveDone)
    begin
      cnt <= (cnt == (slow ? 4'h5 : 4'h0)) ? 4'h0 : cnt + 4'h1;
      if (cnt == (slow ? 4'h5 : 4'h0))
      begin
        descValid <= descReq;
        moveDone  <= moveReq;
        slow      <= ~slow;
      end
    end
    // scrub mode drops the done mark, as the handler would before reuse
    if (doneWrite && !scrub)
      ring[idx][DF_W-1:0] <= doneFlags;
  end
endmodule

// ==== dv/ddc_engine_tb_top.sv ====
// self-checking bench for the descriptor engine, built with and without the completed-descriptor check
`timescale 1ns/10ps
module ddc_engine_tb_top;
  import ddc_pkg::*;
  typedef struct {logic [AW-1:0] b, l, n; logic [4:0] f, err; int irq;} ddc_row_type;
  logic            clock = 0, rstn = 0, curPtrWrite = 0, scrub = 0;
  logic [AW-1:0]   curPtrData = '0, curPtr, descAddr, descBufAddr, descBufLen, descNext;
  logic [31:0]     status;
  logic [DF_W-1:0] descFlags, doneFlags;
  logic            irqPulse, descReq, descValid, doneWrite, moveReq, moveDone;
  logic            packetFirstFlag, packetLastFlag;
  logic [1:0]      pkt;
  logic            offWrite = 0, offReq, offValid, offWb, offMove, offMoveDone;
  logic [AW-1:0]   offAddr, offBufAddr, offBufLen, offNext;
  logic [DF_W-1:0] offFlags, offDoneFlags;
  logic [31:0]     offStatus;
  int              fails = 0, checkCount = 0, irqs = 0, hops = 0, busyRun;
  ddc_row_type rows [7] = '{
    '{32'h1000_0000, 32'h100, 32'h0, 5'h00, 5'h01, 0},
    '{32'h0fff_ff00, 32'h200, 32'h0, 5'h00, 5'h01, 0},
    '{32'h0fff_ff00, 32'h100, 32'h0, 5'h02, 5'h00, 0},
    '{32'h100, 32'h100, 32'h0, 5'h01, 5'h02, 0},
    '{32'h100, 32'h100, 32'h2000_0000, 5'h00, 5'h04, 0},
    '{32'h100, 32'h100, 32'h0, 5'h00, 5'h02, 0},
    '{32'h100, 32'h100, 32'h0, 5'h1e, 5'h00, 1}};
  ddc_engine i_ddc_engine (.clock, .rstn, .curPtrWrite, .curPtrData, .curPtr, .status,
    .irqPulse, .descReq, .descAddr, .descValid, .descBufAddr, .descBufLen, .descNext,
    .descFlags, .doneWrite, .doneFlags, .moveReq, .packetFirstFlag, .packetLastFlag,
    .moveDone);
  ddc_mem_model i_ddc_mem_model (.clock, .scrub, .descReq, .descAddr, .descValid,
    .descBufAddr, .descBufLen, .descNext, .descFlags, .doneWrite, .doneFlags, .moveReq,
    .moveDone);
  // second engine built without the completed-descriptor check
  ddc_engine #(.DONE_RECHECK(1'b0)) i_ddc_engine_off (.clock, .rstn, .curPtrWrite(offWrite),
    .curPtrData, .curPtr(), .status(offStatus), .irqPulse(), .descReq(offReq),
    .descAddr(offAddr), .descValid(offValid), .descBufAddr(offBufAddr),
    .descBufLen(offBufLen), .descNext(offNext), .descFlags(offFlags), .doneWrite(offWb),
    .doneFlags(offDoneFlags), .moveReq(offMove), .packetFirstFlag(), .packetLastFlag(),
    .moveDone(offMoveDone));
  ddc_mem_model i_ddc_mem_model_off (.clock, .scrub(1'b0), .descReq(offReq),
    .descAddr(offAddr), .descValid(offValid), .descBufAddr(offBufAddr),
    .descBufLen(offBufLen), .descNext(offNext), .descFlags(offFlags), .doneWrite(offWb),
    .doneFlags(offDoneFlags), .moveReq(offMove), .moveDone(offMoveDone));
  initial forever #2 clock = ~clock;
  always @(posedge clock)
  begin
    if (irqPulse === 1'b1)
      irqs++;
    if (moveReq === 1'b1)
      pkt <= {packetFirstFlag, packetLastFlag};
    if (descValid === 1'b1 && descAddr === 32'h10)
      hops++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one-cycle pointer write, started right after a rising edge
  task automatic run(input logic [AW-1:0] p);
    curPtrData  <= p;
    curPtrWrite <= 1'b1;
    @(posedge clock);
    curPtrWrite <= 1'b0;
  endtask
  task automatic settle;
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while ((status[ST_BUSY] !== 1'b0 || offStatus[ST_BUSY] !== 1'b0) && n < 400);
    if (n >= 400)
    begin
      fails++;
      close_out();
    end
    else
      @(posedge clock);
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk(status, 32'h0200_0000);
    foreach (rows[i])
    begin
      @(posedge clock);
      i_ddc_mem_model.ring[0] = {rows[i].b, rows[i].l, rows[i].n, rows[i].f};
      irqs = 0;
      pkt = 2'b00;
      run(32'h0);
      @(negedge clock);
      chk(status[ST_BUSY], 1'b1);
      settle();
      chk(status[31:26], {rows[i].err, 1'b0});
      chk(curPtr, 32'h0);
      chk(irqs, rows[i].irq);
      chk(pkt, rows[i].f[4:3]);
      $display("row %0d done", i);
    end
    chk(status[31:27], 5'h00);
    scrub <= 1'b1;
    i_ddc_mem_model.ring[0] = {32'h100, 32'h40, 32'h10, 5'h00};
    i_ddc_mem_model.ring[1] = {32'h200, 32'h40, 32'h0, 5'h00};
    busyRun = 0;
    run(32'h0);
    repeat (120) @(negedge clock) busyRun += int'(status[ST_BUSY] === 1'b1);
    chk(busyRun, 120);
    chk(int'(hops > 1), 1);
    $display("ring test done");
    @(posedge clock);
    run(32'h20);
    settle();
    chk(status[31:26], 6'h20);
    chk(curPtr[5], 1'b0);
    $display("busy write test done");
    scrub <= 1'b0;
    run(32'h1000_0000);
    settle();
    chk(status[31:26], 6'h10);
    $display("pointer error test done");
    i_ddc_mem_model.ring[0] = {32'h100, 32'h40, 32'h10, 5'h00};
    i_ddc_mem_model.ring[1] = {32'h200, 32'h40, 32'h0, 5'h0e};
    irqs = 0;
    run(32'h0);
    settle();
    chk(curPtr, 32'h10);
    chk(irqs, 1);
    repeat (8) @(negedge clock);
    chk(status[31:25], 7'h01);
    $display("stop at second descriptor test done");
    @(posedge clock);
    i_ddc_mem_model_off.ring[0] = {32'h100, 32'h100, 32'h0, 5'h03};
    curPtrData <= 32'h0;
    offWrite   <= 1'b1;
    @(posedge clock);
    offWrite   <= 1'b0;
    @(negedge clock);
    chk(offStatus[ST_BUSY], 1'b1);
    settle();
    chk(offStatus[31:26], 6'h00);
    $display("recheck off test done");
    close_out();
  end
endmodule
